// ===== logic/tgpm_pkg.sv
// tgpm_pkg: constants, register map and carrier types of the ten gig port mac
package tgpm_pkg;
  // ****************************************************************
  // register byte offsets
  // ****************************************************************
  localparam logic [7:0] ADDR_RST    = 8'h00;
  localparam logic [7:0] ADDR_ENA    = 8'h04;
  localparam logic [7:0] ADDR_MODE   = 8'h08;
  localparam logic [7:0] ADDR_MAXLEN = 8'h0C;
  localparam logic [7:0] ADDR_NTAGS  = 8'h10;
  localparam logic [7:0] ADDR_TAG0   = 8'h14;
  localparam logic [7:0] ADDR_TAG1   = 8'h18;
  localparam logic [7:0] ADDR_TAG2   = 8'h1C;
  localparam logic [7:0] ADDR_ADV    = 8'h20;
  localparam logic [7:0] ADDR_LFS    = 8'h24;
  localparam logic [7:0] ADDR_MASK   = 8'h28;
  localparam logic [7:0] ADDR_STAT   = 8'h2C;
  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int POS_SPEED  = 4;
  localparam int POS_TAGCHK = 16;
  localparam int POS_FMASK  = 8;
  localparam int POS_EMASK  = 16;
  localparam int ADV_INR    = 6;
  localparam int ADV_OOR    = 5;
  localparam int LFS_ONEWAY = 1;
  // ****************************************************************
  // reset values and frame constants
  // ****************************************************************
  localparam logic [3:0]  RESETS_INIT = 4'hF;
  localparam logic [1:0]  SPEED_10G   = 2'h0;
  localparam logic [1:0]  SPEED_5G    = 2'h1;
  localparam logic [13:0] MAXLEN_INIT = 14'h05EE;
  localparam logic [1:0]  NTAGS_INIT  = 2'h3;
  localparam logic [15:0] TAG_INIT    = 16'h8100;
  localparam logic [15:0] VLAN_ETYPE  = 16'h8100;
  localparam logic [15:0] PAUSE_ETYPE = 16'h8808;
  localparam logic [15:0] LEN_MAX     = 16'h05DC;
  localparam logic [15:0] TYPE_MIN    = 16'h0600;
  localparam logic [15:0] PAD_MIN     = 16'h002E;
  localparam logic [13:0] HDR_FCS     = 14'h0012;
  localparam logic [13:0] TYPE_POS    = 14'h000D;
  localparam logic [1:0]  FOS_NONE    = 2'h0;
  localparam logic [1:0]  FOS_LOCAL   = 2'h1;
  localparam logic [1:0]  FOS_REMOTE  = 2'h2;
  // ****************************************************************
  // carriers
  // ****************************************************************
  // flags: 0 ext end, 1 ext begin, 2 delimiter, 3 short preamble,
  // 4 preamble, 5 outer header checksum; valid on any byte of a frame
  typedef struct packed {
    logic       valid;
    logic       sop;
    logic       eop;
    logic [7:0] data;
    logic [5:0] flags;
  } tgpm_rx_in_t;
  typedef struct packed {
    logic       valid;
    logic       sop;
    logic       eop;
    logic       abort;
    logic       link_pause;
    logic [7:0] data;
  } tgpm_rx_out_t;
  typedef struct packed {
    logic       valid;
    logic       sop;
    logic       eop;
    logic [7:0] data;
  } tgpm_tx_in_t;
  typedef struct packed {
    logic       valid;
    logic       sop;
    logic       eop;
    logic [7:0] data;
    logic [1:0] fault_os;
  } tgpm_tx_out_t;
  typedef struct packed {
    logic coding_sublayer_irq;
    logic transmit_idle_change_irq;
    logic receive_idle_change_irq;
    logic link_rise_irq;
    logic link_fall_irq;
  } tgpm_irq_t;
  typedef enum logic [1:0] {RX_IDLE, RX_PASS, RX_DROP} tgpm_rx_st_t;
  typedef enum logic {TX_IDLE, TX_FRAME} tgpm_tx_st_t;
endpackage : tgpm_pkg

// ===== logic/tgpm_mac.sv
// tgpm_mac: register file, receive checker and transmit path of the port mac
//
// The register offsets and the APB slave port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module tgpm_mac import tgpm_pkg::*; #(
  parameter int MAX_FRAME_BYTES = 14000
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [7:0]   paddr,
  input  wire logic [31:0]  pwdata,
  output logic [31:0]       prdata,
  output logic              pready,
  output logic              pslverr,
  input  wire tgpm_rx_in_t  rx_in,
  output tgpm_rx_out_t      rx_out,
  input  wire tgpm_tx_in_t  tx_in,
  output logic              tx_ready,
  output tgpm_tx_out_t      tx_out,
  input  wire logic [1:0]   rx_fault,
  input  wire logic [7:0]   coding_events,
  input  wire logic [7:0]   correction_events,
  input  wire logic [7:0]   energy_events,
  input  wire logic         tx_lpi,
  input  wire logic         rx_lpi,
  input  wire logic         link_up,
  output logic              mac_receive_reset,
  output logic              mac_transmit_reset,
  output logic              coding_receive_reset,
  output logic              coding_transmit_reset,
  output logic [1:0]        speed_select,
  output logic              preamble_format_select,
  output logic              gap_format_select,
  output tgpm_irq_t         irq
);
  if (MAX_FRAME_BYTES < 64 || MAX_FRAME_BYTES > 16371) begin : g_bad_len
    $error("MAX_FRAME_BYTES out of range for a 14-bit byte counter");
  end
  localparam logic [13:0] FRAME_CAP = 14'(MAX_FRAME_BYTES);

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    logic              pready;
    logic              pslverr;
    logic [31:0]       prdata;
    logic [3:0]        rst;
    logic [1:0]        speed;
    logic              rxen;
    logic              txen;
    logic [3:0]        mode;
    logic [13:0]       maxlen;
    logic              tagchk;
    logic [1:0]        ntags;
    logic [2:0][15:0]  custom_tag_ethertype;
    logic [6:0]        adv;
    logic              fault_en;
    logic              one_way;
    logic [7:0]        cmask;
    logic [7:0]        fmask;
    logic [7:0]        emask;
    tgpm_rx_st_t       rx_st;
    logic [13:0]       cnt;
    logic [7:0]        shift;
    logic [1:0]        tags;
    logic              scan;
    logic              err;
    logic [15:0]       lt;
    logic              pause;
    tgpm_rx_out_t      rx_out;
    tgpm_tx_st_t       tx_st;
    logic              tx_ready;
    tgpm_tx_out_t      tx_out;
    tgpm_irq_t         irq;
    logic              tx_lpi_q;
    logic              rx_lpi_q;
    logic              link_q;
  } tgpm_state_t;

  tgpm_state_t s;
  tgpm_state_t next_s;
  logic        rx_go;
  logic        tx_go;
  logic        wr_en;

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic [13:0] limit(logic [13:0] mx, logic chk, logic [1:0] t);
    limit = chk ? 14'(mx + {10'h0, t, 2'h0}) : mx;
  endfunction : limit

  function automatic logic is_tag(logic [15:0] w, logic [2:0][15:0] ids);
    is_tag = (w == VLAN_ETYPE) || (w == ids[0]) || (w == ids[1]) || (w == ids[2]);
  endfunction : is_tag

  function automatic logic [32:0] rd(logic [7:0] a, tgpm_state_t st, logic [1:0] flt);
    logic [31:0] d;
    logic        hit;
    d   = '0;
    hit = 1'b1;
    if (a == ADDR_RST) begin
      d[3:0] = st.rst;
      d[POS_SPEED+:2] = st.speed;
    end else if (a == ADDR_ENA) begin
      d[1:0] = {st.txen, st.rxen};
    end else if (a == ADDR_MODE) begin
      d[3:0] = st.mode;
    end else if (a == ADDR_MAXLEN) begin
      d[13:0] = st.maxlen;
      d[POS_TAGCHK] = st.tagchk;
    end else if (a == ADDR_NTAGS) begin
      d[1:0] = st.ntags;
    end else if (a == ADDR_TAG0) begin
      d[15:0] = st.custom_tag_ethertype[0];
    end else if (a == ADDR_TAG1) begin
      d[15:0] = st.custom_tag_ethertype[1];
    end else if (a == ADDR_TAG2) begin
      d[15:0] = st.custom_tag_ethertype[2];
    end else if (a == ADDR_ADV) begin
      d[6:0] = st.adv;
    end else if (a == ADDR_LFS) begin
      d[1:0] = {st.one_way, st.fault_en};
    end else if (a == ADDR_MASK) begin
      d[23:0] = {st.emask, st.fmask, st.cmask};
    end else if (a == ADDR_STAT) begin
      d[3:0] = {flt, st.tx_st == TX_FRAME, st.rx_st != RX_IDLE};
    end else begin
      hit = 1'b0;
    end
    rd = {hit, d};
  endfunction : rd

  assign rx_go = s.rxen && !s.rst[0];
  assign tx_go = s.txen && !s.rst[1];
  assign wr_en = psel && penable && s.pready && pwrite;

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    logic [32:0] r;
    logic [15:0] w;
    logic [13:0] c;
    logic [13:0] lim;
    logic [13:0] pl;
    logic [1:0]  tg;
    logic        inr;
    logic        oor;
    logic        take;
    logic        block;
    r     = rd(paddr, s, rx_fault);
    w     = {s.shift, rx_in.data};
    c     = rx_in.sop ? 14'h0000 : s.cnt;
    tg    = rx_in.sop ? 2'h0 : s.tags;
    lim   = '0;
    pl    = '0;
    inr   = 1'b0;
    oor   = 1'b0;
    take  = tx_in.valid && s.tx_ready && tx_go;
    block = s.fault_en && |rx_fault && !s.one_way;
    next_s = s;

    // zero wait states: answer in the first access cycle
    next_s.pready  = psel && !penable;
    next_s.pslverr = psel && !penable && !r[32];
    next_s.prdata  = (psel && !penable) ? r[31:0] : '0;
    if (wr_en) begin
      if (paddr == ADDR_RST) begin
        next_s.rst   = pwdata[3:0];
        next_s.speed = pwdata[POS_SPEED+:2];
      end else if (paddr == ADDR_ENA) begin
        next_s.rxen = pwdata[0];
        next_s.txen = pwdata[1];
      end else if (paddr == ADDR_MODE) begin
        next_s.mode = pwdata[3:0];
      end else if (paddr == ADDR_MAXLEN) begin
        // limit is clamped to the supported size; with tag checking the counter may pass it by four bytes per counted tag
        next_s.maxlen = (pwdata[13:0] > FRAME_CAP) ? FRAME_CAP : pwdata[13:0];
        next_s.tagchk = pwdata[POS_TAGCHK];
      end else if (paddr == ADDR_NTAGS) begin
        next_s.ntags = pwdata[1:0];
      end else if (paddr == ADDR_TAG0) begin
        next_s.custom_tag_ethertype[0] = pwdata[15:0];
      end else if (paddr == ADDR_TAG1) begin
        next_s.custom_tag_ethertype[1] = pwdata[15:0];
      end else if (paddr == ADDR_TAG2) begin
        next_s.custom_tag_ethertype[2] = pwdata[15:0];
      end else if (paddr == ADDR_ADV) begin
        next_s.adv = pwdata[6:0];
      end else if (paddr == ADDR_LFS) begin
        next_s.fault_en = pwdata[0];
        next_s.one_way  = pwdata[LFS_ONEWAY];
      end else if (paddr == ADDR_MASK) begin
        next_s.cmask = pwdata[7:0];
        next_s.fmask = pwdata[POS_FMASK+:8];
        next_s.emask = pwdata[POS_EMASK+:8];
      end
    end

    // receive path
    next_s.rx_out = '0;
    if (!rx_go) begin
      next_s.rx_st = RX_IDLE;
    end else if (rx_in.valid) begin
      next_s.shift = rx_in.data;
      if (s.rx_st == RX_DROP && !rx_in.sop) begin
        if (rx_in.eop) begin
          next_s.rx_st = RX_IDLE;
        end
      end else if (s.rx_st == RX_PASS || rx_in.sop) begin
        if (rx_in.sop) begin
          next_s.scan  = 1'b1;
          next_s.err   = 1'b0;
          next_s.lt    = '0;
          next_s.pause = 1'b0;
        end
        // type field sits after each tag; stop at the first non-tag or once ntags tags are counted
        if ((rx_in.sop || s.scan) && c == 14'(TYPE_POS + {10'h0, tg, 2'h0})) begin
          if (is_tag(w, s.custom_tag_ethertype) && tg < s.ntags) begin
            tg = 2'(tg + 2'h1);
          end else begin
            next_s.scan  = 1'b0;
            next_s.lt    = w;
            next_s.pause = (w == PAUSE_ETYPE);
          end
        end
        next_s.err = (rx_in.sop ? 1'b0 : s.err) |
                     (rx_in.flags[0] & s.adv[0]) | (rx_in.flags[1] & s.adv[1]) |
                     (rx_in.flags[2] & s.adv[2]) | (rx_in.flags[3] & !s.adv[3]) |
                     (rx_in.flags[4] & s.adv[4]) | (rx_in.flags[5] & s.mode[3]);
        next_s.tags = tg;
        next_s.cnt  = 14'(c + 14'h0001);
        lim = limit(s.maxlen, s.tagchk, tg);
        pl  = 14'(c + 14'h0001 - HDR_FCS - {10'h0, tg, 2'h0});
        if (!next_s.scan && (c + 14'h0001) >= 14'(HDR_FCS + {10'h0, tg, 2'h0})) begin
          inr = s.adv[ADV_INR] && next_s.lt <= LEN_MAX &&
                (next_s.lt > {2'h0, pl} || (next_s.lt >= PAD_MIN && next_s.lt != {2'h0, pl}));
          oor = s.adv[ADV_OOR] && next_s.lt > LEN_MAX && next_s.lt < TYPE_MIN;
        end
        next_s.rx_out.valid = 1'b1;
        next_s.rx_out.sop   = rx_in.sop;
        next_s.rx_out.data  = rx_in.data;
        if (14'(c + 14'h0001) == lim && !rx_in.eop) begin
          next_s.rx_out.eop   = 1'b1;
          next_s.rx_out.abort = 1'b1;
          next_s.rx_st        = RX_DROP;
        end else if (rx_in.eop) begin
          next_s.rx_out.eop        = 1'b1;
          next_s.rx_out.abort      = next_s.err | inr | oor;
          next_s.rx_out.link_pause = next_s.pause && !s.mode[0];
          next_s.rx_st             = RX_IDLE;
        end else begin
          next_s.rx_st = RX_PASS;
        end
      end
    end

    // transmit path
    next_s.tx_out = '0;
    if (take) begin
      next_s.tx_out.valid = 1'b1;
      next_s.tx_out.sop   = tx_in.sop;
      next_s.tx_out.eop   = tx_in.eop;
      next_s.tx_out.data  = tx_in.data;
      next_s.tx_st        = tx_in.eop ? TX_IDLE : TX_FRAME;
    end else if (!tx_go) begin
      next_s.tx_st = TX_IDLE;
    end
    if (!take && next_s.tx_st == TX_IDLE && s.fault_en && rx_fault[0]) begin
      next_s.tx_out.fault_os = FOS_REMOTE;
    end
    // a fault only stalls new frames; the one under way completes
    next_s.tx_ready = next_s.txen && !next_s.rst[1] &&
                      !(block && next_s.tx_st == TX_IDLE);

    // interrupt indications
    next_s.irq.coding_sublayer_irq = |(coding_events & s.cmask) |
                                     |(correction_events & s.fmask) |
                                     |(energy_events & s.emask);
    next_s.irq.transmit_idle_change_irq = tx_lpi != s.tx_lpi_q;
    next_s.irq.receive_idle_change_irq  = rx_lpi != s.rx_lpi_q;
    next_s.irq.link_rise_irq = link_up && !s.link_q;
    next_s.irq.link_fall_irq = !link_up && s.link_q;
    next_s.tx_lpi_q = tx_lpi;
    next_s.rx_lpi_q = rx_lpi;
    next_s.link_q   = link_up;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s          <= '0;
      s.rst      <= RESETS_INIT;
      s.speed    <= SPEED_10G;
      s.maxlen   <= MAXLEN_INIT;
      s.ntags    <= NTAGS_INIT;
      s.custom_tag_ethertype <= {TAG_INIT, TAG_INIT, TAG_INIT};
      s.fault_en <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign prdata                 = s.prdata;
  assign pready                 = s.pready;
  assign pslverr                = s.pslverr;
  assign rx_out                 = s.rx_out;
  assign tx_ready               = s.tx_ready;
  assign tx_out                 = s.tx_out;
  assign mac_receive_reset      = s.rst[0];
  assign mac_transmit_reset     = s.rst[1];
  assign coding_receive_reset   = s.rst[2];
  assign coding_transmit_reset  = s.rst[3];
  assign speed_select           = s.speed;
  assign preamble_format_select = s.mode[1];
  assign gap_format_select      = s.mode[2];
  assign irq                    = s.irq;

  // ****************************************************************
  // checks
  // ****************************************************************
  logic block_now;
  assign block_now = s.fault_en && |rx_fault && !s.one_way;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_rst_after_release: assert property (!$past(presetn) |-> s.rst == RESETS_INIT)
    else $error("resets not asserted after power-up");
  chk_rst_write_any: assert property (wr_en && paddr == ADDR_RST |=>
      {coding_transmit_reset, coding_receive_reset, mac_transmit_reset, mac_receive_reset}
      == $past(pwdata[3:0]))
    else $error("reset bits do not follow the write");
  chk_speed_field: assert property (wr_en && paddr == ADDR_RST |=>
      speed_select == $past(pwdata[POS_SPEED+:2]))
    else $error("speed select does not follow the write");
  chk_rx_quiet: assert property (!rx_go |=> !rx_out.valid)
    else $error("receive output active while disabled or in reset");
  chk_tx_quiet: assert property (!tx_go |=> !tx_out.valid ##1 !tx_out.valid || tx_go)
    else $error("transmit output active while disabled or in reset");
  chk_rx_length_cap: assert property (rx_out.valid && !rx_out.abort |->
      s.cnt <= limit(s.maxlen, s.tagchk, s.tags))
    else $error("frame forwarded past the length limit");
  chk_coding_masked: assert property ((s.cmask == 8'h00 && s.fmask == 8'h00 &&
      s.emask == 8'h00) [*2] |-> !irq.coding_sublayer_irq)
    else $error("coding interrupt raised with every mask clear");
  chk_fault_reply: assert property (s.fault_en && rx_fault[0] && !tx_in.valid &&
      s.tx_st == TX_IDLE |=> tx_out.fault_os == FOS_REMOTE)
    else $error("no fault ordered set after received fault");
  chk_fault_off: assert property (!s.fault_en |=> tx_out.fault_os == FOS_NONE)
    else $error("fault ordered set sent with signaling off");
  chk_bidir_hold: assert property ((block_now && s.tx_st == TX_IDLE) [*2] |=>
      !tx_out.valid)
    else $error("frame started during fault in two-way mode");
  chk_link_rise: assert property ($rose(link_up) |=> irq.link_rise_irq ##1 !irq.link_rise_irq)
    else $error("link rise indication not a single pulse");

  cov_truncate: cover property (rx_out.valid && rx_out.eop && rx_out.abort);
  cov_three_tags: cover property (rx_out.valid && rx_out.eop && s.tags == 2'h3);
  cov_one_way_frame: cover property (s.one_way && |rx_fault && tx_out.valid);
  cov_reset_cycle: cover property (wr_en && paddr == ADDR_RST && pwdata[3:0] == 4'hF
      ##[1:20] wr_en && paddr == ADDR_RST && pwdata[3:0] == 4'h0);
endmodule : tgpm_mac
`default_nettype wire

// ===== verification/tgpm_lane_model.sv
// tgpm_lane_model: coding sublayer stand-in on the receive and transmit lanes
`timescale 1ns/1ps
`default_nettype none
module tgpm_lane_model import tgpm_pkg::*; (
  input  wire logic         pclk,
  output tgpm_rx_in_t       rx_in,
  input  wire tgpm_tx_out_t tx_out
);
  int n_tx = 0;
  initial rx_in = '0;
  always @(posedge pclk) begin
    if (tx_out.valid) begin
      n_tx <= n_tx + 1;
    end
  end
  // ******
  // frame source
  // ******
  // bytes carry their index except the type field; flags ride on every byte
  task automatic send(input int len, input logic [15:0] et, input logic [5:0] fl);
    logic [7:0] b;
    for (int i = 0; i < len; i++) begin
      b = (i == 12) ? et[15:8] : (i == 13) ? et[7:0] : 8'(i);
      rx_in <= '{1'b1, i == 0, i == len - 1, b, fl};
      @(posedge pclk);
    end
    // released lane shows the inverse so a stale byte never looks live
    rx_in <= '{1'b0, 1'b0, 1'b0, ~b, 6'h00};
  endtask : send
endmodule : tgpm_lane_model
`default_nettype wire

// ===== verification/ten_gig_port_mac_tb.sv
// ten_gig_port_mac_tb: register, receive, transmit, fault and interrupt tests
`timescale 1ns/1ps
`default_nettype none
module ten_gig_port_mac_tb import tgpm_pkg::*;;
  logic         pclk;
  logic         presetn = 1'b0;
  logic         psel = 1'b0;
  logic         penable = 1'b0;
  logic         pwrite = 1'b0;
  logic [7:0]   paddr = 8'h00;
  logic [31:0]  pwdata = 32'h0;
  logic [31:0]  prdata, q, base;
  logic         pready, pslverr, tx_ready, e, last_ab, last_ps, pfmt, gfmt;
  tgpm_rx_in_t  rx_in;
  tgpm_rx_out_t rx_out;
  tgpm_tx_in_t  tx_in = '0;
  tgpm_tx_out_t tx_out;
  tgpm_irq_t    irq;
  logic [1:0]   rx_fault = 2'h0;
  logic [7:0]   coding_events = 8'h00;
  logic [7:0]   idle_ev = 8'h00;
  logic         idle_b = 1'b0;
  logic [3:0]   resets;
  logic [1:0]   speed;
  logic [31:0]  run = 0;
  logic [31:0]  last_len = 0;
  logic [31:0]  rx_total = 0;
  int           n_fail = 0;
  int           total_checks = 0;
  tgpm_mac dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .rx_in, .rx_out, .tx_in, .tx_ready, .tx_out, .rx_fault, .coding_events,
    .correction_events(idle_ev), .energy_events(idle_ev), .tx_lpi(idle_b),
    .rx_lpi(idle_b), .link_up(idle_b), .mac_receive_reset(resets[0]),
    .mac_transmit_reset(resets[1]), .coding_receive_reset(resets[2]),
    .coding_transmit_reset(resets[3]), .speed_select(speed),
    .preamble_format_select(pfmt), .gap_format_select(gfmt), .irq
  );
  tgpm_lane_model lane (.pclk, .rx_in, .tx_out);
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    if (rx_out.valid) begin
      rx_total <= rx_total + 1;
      run <= rx_out.eop ? 32'h0 : run + 1;
      if (rx_out.eop) begin
        last_len <= run + 1;
        last_ab <= rx_out.abort;
        last_ps <= rx_out.link_pause;
      end
    end
  end
  // ******
  // tasks
  // ******
  task automatic report_and_stop;
    $display("checks %0d failures %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [31:0] got, exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
    if (k >= 20) begin
      n_fail++;
      report_and_stop();
    end
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(q, x);
    chk({31'h0, e}, 32'h0);
  endtask : rd
  task automatic waitc(input int n);
    repeat (n) @(posedge pclk);
  endtask : waitc
  task automatic run_rx(input logic [31:0] ml, adv, input logic [15:0] et, input int len,
      input logic [5:0] fl, input logic [31:0] el, input logic ea, ep);
    wr(ADDR_MAXLEN, ml);
    wr(ADDR_ADV, adv);
    lane.send(len, et, fl);
    waitc(3);
    chk(last_len, el);
    chk({30'h0, last_ab, last_ps}, {30'h0, ea, ep});
    $display("receive case done");
  endtask : run_rx
  task automatic quiet_rx;
    base = rx_total;
    lane.send(20, 16'h0800, 6'h00);
    waitc(3);
    chk(rx_total, base);
  endtask : quiet_rx
  task automatic send_tx(input int exp);
    int k;
    for (int i = 0; i < 4; i++) begin
      tx_in <= '{1'b1, i == 0, i == 3, 8'(i)};
      k = 0;
      do begin
        @(posedge pclk);
        k++;
      end while (tx_ready !== 1'b1 && k < 20);
      if (tx_ready !== 1'b1) begin
        n_fail++;
        report_and_stop();
      end
    end
    tx_in <= '0;
    waitc(3);
    chk(32'(lane.n_tx), 32'(exp));
  endtask : send_tx
  // ******
  // main sequence
  // ******
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk({28'h0, resets}, 32'h0000000F);
    rd(ADDR_RST, 32'h0000000F);
    rd(ADDR_MAXLEN, 32'h000005EE);
    rd(ADDR_TAG2, 32'h00008100);
    apb(1'b0, 8'h40, 32'h0);
    chk(q, 32'h0);
    chk({31'h0, e}, 32'h1);
    wr(ADDR_RST, 32'h0000001F);
    wr(ADDR_RST, 32'h00000010);
    chk({26'h0, speed, resets}, 32'h00000010);
    wr(ADDR_ENA, 32'h00000003);
    send_tx(4);
    run_rx(32'h40, 32'h0, 16'h0800, 80, 6'h00, 32'd64, 1'b1, 1'b0);
    run_rx(32'h10040, 32'h0, 16'h8100, 80, 6'h00, 32'd68, 1'b1, 1'b0);
    run_rx(32'h40, 32'h0, 16'h8100, 80, 6'h00, 32'd64, 1'b1, 1'b0);
    wr(ADDR_TAG0, 32'h00009100);
    run_rx(32'h10040, 32'h0, 16'h9100, 80, 6'h00, 32'd68, 1'b1, 1'b0);
    run_rx(32'h5EE, 32'h0, PAUSE_ETYPE, 30, 6'h00, 32'd30, 1'b0, 1'b1);
    run_rx(32'h5EE, 32'h4, 16'h0800, 20, 6'h04, 32'd20, 1'b1, 1'b0);
    run_rx(32'h5EE, 32'h0, 16'h0800, 20, 6'h08, 32'd20, 1'b1, 1'b0);
    run_rx(32'h5EE, 32'h8, 16'h0800, 20, 6'h08, 32'd20, 1'b0, 1'b0);
    wr(ADDR_MODE, 32'h0000000F);
    chk({30'h0, pfmt, gfmt}, 32'h00000003);
    run_rx(32'h5EE, 32'h0, PAUSE_ETYPE, 30, 6'h00, 32'd30, 1'b0, 1'b0);
    run_rx(32'h5EE, 32'h0, 16'h0800, 20, 6'h20, 32'd20, 1'b1, 1'b0);
    wr(ADDR_MODE, 32'h00000000);
    run_rx(32'h5EE, 32'h0, 16'h0800, 20, 6'h20, 32'd20, 1'b0, 1'b0);
    run_rx(32'h5EE, 32'h40, 16'h0010, 30, 6'h00, 32'd30, 1'b1, 1'b0);
    run_rx(32'h5EE, 32'h40, 16'h000C, 30, 6'h00, 32'd30, 1'b0, 1'b0);
    run_rx(32'h5EE, 32'h20, 16'h05DD, 30, 6'h00, 32'd30, 1'b1, 1'b0);
    wr(ADDR_NTAGS, 32'h00000000);
    rd(ADDR_NTAGS, 32'h00000000);
    run_rx(32'h10040, 32'h0, 16'h8100, 80, 6'h00, 32'd64, 1'b1, 1'b0);
    wr(ADDR_ENA, 32'h00000002);
    quiet_rx();
    wr(ADDR_ENA, 32'h00000003);
    wr(ADDR_RST, 32'h00000011);
    chk({26'h0, speed, resets}, 32'h00000011);
    quiet_rx();
    wr(ADDR_RST, 32'h00000010);
    $display("enable and reset test done");
    rx_fault <= 2'h1;
    waitc(3);
    chk({30'h0, tx_out.fault_os}, {30'h0, FOS_REMOTE});
    chk({31'h0, tx_ready}, 32'h0);
    rd(ADDR_STAT, 32'h00000004);
    wr(ADDR_LFS, 32'h00000003);
    send_tx(8);
    wr(ADDR_LFS, 32'h00000000);
    waitc(2);
    chk({30'h0, tx_out.fault_os}, {30'h0, FOS_NONE});
    rx_fault <= 2'h0;
    $display("fault test done");
    wr(ADDR_MASK, 32'h00000001);
    coding_events <= 8'h01;
    waitc(3);
    chk({31'h0, irq.coding_sublayer_irq}, 32'h1);
    wr(ADDR_MASK, 32'h00000100);
    waitc(2);
    chk({31'h0, irq.coding_sublayer_irq}, 32'h0);
    idle_ev <= 8'h01;
    waitc(2);
    chk({31'h0, irq.coding_sublayer_irq}, 32'h1);
    wr(ADDR_MASK, 32'h00000000);
    idle_b <= 1'b1;
    waitc(2);
    chk({27'h0, irq}, 32'h0000000E);
    waitc(1);
    chk({27'h0, irq}, 32'h00000000);
    idle_b <= 1'b0;
    waitc(2);
    chk({27'h0, irq}, 32'h0000000D);
    $display("interrupt test done");
    report_and_stop();
  end
endmodule : ten_gig_port_mac_tb
`default_nettype wire
